// ===== logic/uart_chan_pkg.sv
// Shared constants and types for the UART channel
package uart_chan_pkg;
  localparam int FIFO_DEPTH = 64;
  localparam int OVERSAMPLE = 16;
  localparam int HALF_BIT = 8;
  localparam int IDLE_CHARS = 4;
  localparam logic [2:0] ADDR_HOLD = 3'h0;
  localparam logic [2:0] ADDR_IER = 3'h1;
  localparam logic [2:0] ADDR_IIR_FCR = 3'h2;
  localparam logic [2:0] ADDR_LCR = 3'h3;
  localparam logic [2:0] ADDR_MCR = 3'h4;
  localparam logic [2:0] ADDR_LSR = 3'h5;
  localparam logic [2:0] ADDR_MSR = 3'h6;
  localparam logic [2:0] ADDR_SCRATCH = 3'h7;
  localparam logic [7:0] LCR_RESET = 8'h1D;
  localparam logic [7:0] ENH_KEY = 8'hBF;
  localparam int LCR_DIVISOR_LATCH_ACCESS = 7;
  localparam int LCR_BREAK = 6;
  localparam int LCR_PAR_FORCE = 5;
  localparam int LCR_PAR_EVEN = 4;
  localparam int LCR_PAR_EN = 3;
  localparam int LCR_STOP = 2;
  localparam int EFR_ENH = 4;
  localparam int IER_SLEEP = 4;
  localparam int IER_MODEM = 3;
  localparam int IER_LINE = 2;
  localparam int IER_THR = 1;
  localparam int IER_RXD = 0;
  localparam int MCR_PRESC = 7;
  localparam int MCR_THR_ACC = 6;
  localparam int MCR_LOOP = 4;
  localparam int MCR_RDY_EN = 2;
  localparam int FCR_EN = 0;
  localparam int FCR_RX_CLR = 1;
  localparam int FCR_TX_CLR = 2;
  localparam int FCR_DMA = 3;
  localparam logic [2:0] PRIO_LINE = 3'h3;
  localparam logic [2:0] PRIO_RXD = 3'h2;
  localparam logic [2:0] PRIO_THR = 3'h1;
  localparam logic [2:0] PRIO_MODEM = 3'h0;

  typedef enum logic [2:0] {LS_IDLE, LS_START, LS_DATA, LS_PAR, LS_STOP} line_state_t;

  typedef struct packed {
    logic brk;
    logic frame_err;
    logic par_err;
    logic [7:0] data;
  } rx_entry_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic all_cs;
    logic [2:0] addr;
    logic [7:0] wdata;
  } bus_req_t;
endpackage : uart_chan_pkg

// ===== logic/hold_fifo.sv
// Holding FIFO with valid/ready on both sides and single-entry mode
`timescale 1ns/1ps
module hold_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Mode
  input wire logic i_clear,
  input wire logic i_single,
  input wire logic i_overwrite,
  // Fill side
  input wire logic i_s_valid,
  output logic o_s_ready,
  input wire logic [WIDTH-1:0] i_s_data,
  // Drain side
  output logic o_m_valid,
  input wire logic i_m_ready,
  output logic [WIDTH-1:0] o_m_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("hold_fifo DEPTH must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_state_t;

  fifo_state_t s;
  fifo_state_t n;
  logic full;
  logic push;
  logic pop;

  always_comb begin
    n = s;
    full = s.cnt >= (i_single ? (AW + 1)'(1) : (AW + 1)'(DEPTH));
    o_s_ready = ~full | (i_single & i_overwrite);
    o_m_valid = s.cnt != '0;
    o_m_data = s.mem[s.rp];
    push = i_s_valid & o_s_ready;
    pop = o_m_valid & i_m_ready;
    if (i_clear) begin
      n.wp = '0;
      n.rp = '0;
      n.cnt = '0;
    end else begin
      if (pop) begin
        n.rp = s.rp + 1'b1;
      end
      // Single entry kept full: replace it instead of growing
      if (push && full && !pop) begin
        n.mem[s.rp] = i_s_data;
      end else if (push) begin
        n.mem[s.wp] = i_s_data;
        n.wp = s.wp + 1'b1;
      end
      n.cnt = s.cnt + (AW + 1)'(push && !(full && !pop)) - (AW + 1)'(pop);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
endmodule : hold_fifo

// ===== logic/baud_gen.sv
// Prescaler and 16-bit divisor producing the 16x bit-rate tick
`timescale 1ns/1ps
module baud_gen import uart_chan_pkg::*; (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Control
  input wire logic i_run,
  input wire logic i_presc4,
  input wire logic [15:0] i_div,
  // Tick
  output logic o_tick16
);
  typedef struct packed {
    logic [1:0] pre;
    logic [15:0] cnt;
    logic tick;
  } baud_state_t;

  baud_state_t s;
  baud_state_t n;
  logic pre_tick;

  always_comb begin
    n = s;
    n.tick = 1'b0;
    pre_tick = i_presc4 ? (s.pre == 2'h3) : 1'b1;
    // Zero divisor or sleep: counters cleared, no tick
    if (!i_run || i_div == 16'h0000) begin
      n.pre = '0;
      n.cnt = '0;
    end else begin
      n.pre = i_presc4 ? s.pre + 2'h1 : 2'h0;
      if (pre_tick) begin
        if (s.cnt >= i_div - 16'h0001) begin
          n.cnt = '0;
          n.tick = 1'b1;
        end else begin
          n.cnt = s.cnt + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign o_tick16 = s.tick;
endmodule : baud_gen

// ===== logic/uart_channel.sv
// One UART channel: register port, serial engines, idle and sleep control
`timescale 1ns/1ps
// Function
// - Sleep allowed only with enhanced functions and sleep enable both set.
// - Sleep entered when RX idle, TX empty, only the TX_HOLDING_FIFO interrupt pending.
// - Never sleep while the receive FIFO holds a character.
// - Asleep: internal and baud clocks stop.
// - Wake on RX change, modem input change, or transmit FIFO write.
// - RX idle flagged after line high for four character times.
// - Receiver samples RX at the middle of each bit.
// - Break bit forces TX low while set, except in loopback, where TX stays at mark.
// - Baud generator divides by a 16-bit divisor, 1 to 65535.
// - Prescaler bit adds divide-by-4; reset default is divide-by-1.
// - Baud generator output runs at sixteen times the bit rate.
// - Divisor bytes form the divisor; zero divisor stops the baud clock.
// - One baud generator times both transmitter and receiver.
// - Three address lines select the general register set.
// - Line control BFh maps addresses 2,4,5,6,7 to enhanced and flow characters.
// - Addresses 6,7 reach threshold registers when enhanced and access bits set.
// - FIFO ready register readable at 7 with all selects, enable, no loopback.
// - Enhanced control bits writable only with enhanced functions set.
// - 64-entry receive FIFO; disabled mode overwrites the held entry.
// - Each receive entry keeps its error bits with the character.
// - 64-entry transmit FIFO; disabled mode stores one byte, overflow lost.
// - FIFO enable bit enables or disables both FIFOs.
module uart_channel import uart_chan_pkg::*; #(
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Register port
  input wire logic i_cs_n,
  input wire logic i_all_cs_n,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  // Ready status of sibling channels D..B
  input wire logic [2:0] i_peer_rx_rdy,
  input wire logic [2:0] i_peer_tx_rdy,
  // Serial and modem pins, modem as {cd, ri, dsr, cts}
  input wire logic i_rx,
  input wire logic [3:0] i_modem_n,
  output logic o_tx,
  // Status
  output logic o_asleep,
  output logic o_rx_idle
);
  typedef struct packed {
    logic rx_s1;
    logic rx_s2;
    logic rx_last;
    logic [3:0] ms_s1;
    logic [3:0] ms_s2;
    logic [3:0] msr_lvl;
    logic [3:0] msr_delta;
    logic [7:0] interrupt_enable;
    logic [7:0] line_control;
    logic [7:0] modem_control;
    logic [7:0] enhanced_features;
    logic [7:0] dll;
    logic [7:0] divisor_high_byte;
    logic [7:0] scratch_byte;
    logic [7:0] resume_char_one;
    logic [7:0] resume_char_two;
    logic [7:0] halt_char_one;
    logic [7:0] halt_char_two;
    logic [7:0] flow_thresholds;
    logic [7:0] fifo_trigger_levels;
    logic fifo_en;
    logic dma_mode;
    logic [1:0] rx_trig;
    logic [1:0] tx_trig;
    logic overrun;
    logic asleep;
    logic rx_idle;
    logic [9:0] idle_cnt;
    line_state_t tx_st;
    logic [5:0] tx_cnt;
    logic [2:0] tx_bit;
    logic [7:0] tx_sh;
    logic tx_par;
    logic tx_line;
    logic tx_out;
    line_state_t rx_st;
    logic [5:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_par;
    logic [7:0] rdata;
  } chan_state_t;

  chan_state_t s;
  chan_state_t n;
  bus_req_t req;
  rx_entry_t rx_ent;
  rx_entry_t rx_top;
  logic [7:0] tx_top;
  logic tick;
  logic rx_in;
  logic rx_push, rx_pop, rx_valid, rx_ready, rx_clr;
  logic tx_push, tx_pop, tx_valid, tx_ready, tx_clr;
  logic [3:0] msr_now;
  logic [3:0] wl;
  logic [7:0] d;
  logic bf, tcr_ok, allowed, wake, pend, thr_pend, enh;
  logic [2:0] prio;

  function automatic logic [3:0] word_len(input logic [7:0] line_control);
    return 4'd5 + {2'b00, line_control[1:0]};
  endfunction : word_len

  function automatic logic [7:0] data_mask(input logic [7:0] line_control);
    return 8'hFF >> (4'd8 - word_len(line_control));
  endfunction : data_mask

  function automatic logic [5:0] stop_ticks(input logic [7:0] line_control);
    if (!line_control[LCR_STOP]) begin
      return 6'(OVERSAMPLE);
    end else if (line_control[1:0] == 2'h0) begin
      return 6'(OVERSAMPLE * 3 / 2);
    end
    return 6'(OVERSAMPLE * 2);
  endfunction : stop_ticks

  function automatic logic [9:0] char_ticks(input logic [7:0] line_control);
    return 10'(OVERSAMPLE) * (10'd1 + 10'(word_len(line_control)) + 10'(line_control[LCR_PAR_EN]))
      + 10'(stop_ticks(line_control));
  endfunction : char_ticks

  function automatic logic par_bit(input logic [7:0] line_control, input logic [7:0] data);
    if (line_control[LCR_PAR_FORCE]) begin
      return ~line_control[LCR_PAR_EVEN];
    end
    return line_control[LCR_PAR_EVEN] ? ^(data & data_mask(line_control)) : ~^(data & data_mask(line_control));
  endfunction : par_bit

  function automatic chan_state_t reset_state();
    chan_state_t r;
    r = '0;
    r.rx_s1 = 1'b1;
    r.rx_s2 = 1'b1;
    r.rx_last = 1'b1;
    r.ms_s1 = 4'hF;
    r.ms_s2 = 4'hF;
    r.line_control = LCR_RESET;
    r.tx_line = 1'b1;
    r.tx_out = 1'b1;
    return r;
  endfunction : reset_state

  // Single rate source for both directions
  baud_gen u_baud (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_run(~s.asleep),
    .i_presc4(s.modem_control[MCR_PRESC]),
    .i_div({s.divisor_high_byte, s.dll}),
    .o_tick16(tick)
  );

  hold_fifo #(.WIDTH($bits(rx_entry_t)), .DEPTH(DEPTH)) u_rx_fifo (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_clear(rx_clr),
    .i_single(~s.fifo_en),
    .i_overwrite(1'b1),
    .i_s_valid(rx_push),
    .o_s_ready(rx_ready),
    .i_s_data(rx_ent),
    .o_m_valid(rx_valid),
    .i_m_ready(rx_pop),
    .o_m_data(rx_top)
  );

  hold_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_fifo (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_clear(tx_clr),
    .i_single(~s.fifo_en),
    .i_overwrite(1'b0),
    .i_s_valid(tx_push),
    .o_s_ready(tx_ready),
    .i_s_data(req.wdata),
    .o_m_valid(tx_valid),
    .i_m_ready(tx_pop),
    .o_m_data(tx_top)
  );

  always_comb begin
    n = s;
    req = '{rd: ~i_cs_n & ~i_rd_n, wr: ~i_cs_n & ~i_wr_n, all_cs: ~i_all_cs_n,
      addr: i_addr, wdata: i_wdata};
    rx_push = 1'b0;
    rx_pop = 1'b0;
    rx_clr = 1'b0;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    tx_clr = 1'b0;
    rx_ent = '0;
    d = '0;
    wl = word_len(s.line_control);
    bf = s.line_control == ENH_KEY;
    enh = s.enhanced_features[EFR_ENH];
    tcr_ok = enh & s.modem_control[MCR_THR_ACC];
    rx_in = s.modem_control[MCR_LOOP] ? s.tx_line : s.rx_s2;
    // Pins are active low; loopback feeds modem controls back in
    msr_now = s.modem_control[MCR_LOOP] ? {s.modem_control[3], s.modem_control[2], s.modem_control[0], s.modem_control[1]} : ~s.ms_s2;

    n.rx_s1 = i_rx;
    n.rx_s2 = s.rx_s1;
    n.ms_s1 = i_modem_n;
    n.ms_s2 = s.ms_s1;
    n.rx_last = rx_in;
    n.msr_lvl = msr_now;
    n.msr_delta = s.msr_delta | (msr_now ^ s.msr_lvl);

    thr_pend = s.interrupt_enable[IER_THR] & ~tx_valid;
    pend = 1'b1;
    prio = PRIO_MODEM;
    if (s.interrupt_enable[IER_LINE] && (s.overrun || (rx_valid && (rx_top.brk || rx_top.frame_err
        || rx_top.par_err)))) begin
      prio = PRIO_LINE;
    end else if (s.interrupt_enable[IER_RXD] && rx_valid) begin
      prio = PRIO_RXD;
    end else if (thr_pend) begin
      prio = PRIO_THR;
    end else if (!(s.interrupt_enable[IER_MODEM] && s.msr_delta != 4'h0)) begin
      pend = 1'b0;
    end

    // Register reads
    if (req.rd) begin
      case (req.addr)
        ADDR_HOLD: begin
          if (s.line_control[LCR_DIVISOR_LATCH_ACCESS]) begin
            n.rdata = s.dll;
          end else begin
            n.rdata = rx_top.data;
            rx_pop = rx_valid;
          end
        end
        ADDR_IER: n.rdata = s.line_control[LCR_DIVISOR_LATCH_ACCESS] ? s.divisor_high_byte : s.interrupt_enable;
        ADDR_IIR_FCR: n.rdata = bf ? s.enhanced_features : {s.fifo_en, s.fifo_en, 2'b00, prio, ~pend};
        ADDR_LCR: n.rdata = s.line_control;
        ADDR_MCR: n.rdata = bf ? s.resume_char_one : s.modem_control;
        ADDR_LSR: begin
          if (bf) begin
            n.rdata = s.resume_char_two;
          end else begin
            n.rdata = {rx_valid & (rx_top.brk | rx_top.frame_err | rx_top.par_err),
              ~tx_valid & (s.tx_st == LS_IDLE), ~tx_valid,
              rx_valid & rx_top.brk, rx_valid & rx_top.frame_err,
              rx_valid & rx_top.par_err, s.overrun, rx_valid};
            n.overrun = 1'b0;
          end
        end
        ADDR_MSR: begin
          if (bf) begin
            n.rdata = s.halt_char_one;
          end else if (tcr_ok) begin
            n.rdata = s.flow_thresholds;
          end else begin
            n.rdata = {s.msr_lvl, s.msr_delta};
            n.msr_delta = msr_now ^ s.msr_lvl;
          end
        end
        ADDR_SCRATCH: begin
          if (bf) begin
            n.rdata = s.halt_char_two;
          end else if (req.all_cs && s.modem_control[MCR_RDY_EN] && !s.modem_control[MCR_LOOP]) begin
            n.rdata = {i_peer_rx_rdy, rx_valid, i_peer_tx_rdy, tx_ready};
          end else if (tcr_ok) begin
            n.rdata = s.fifo_trigger_levels;
          end else begin
            n.rdata = s.scratch_byte;
          end
        end
        default: n.rdata = 8'h00;
      endcase
    end

    // Register writes
    if (req.wr) begin
      case (req.addr)
        ADDR_HOLD: begin
          if (s.line_control[LCR_DIVISOR_LATCH_ACCESS]) begin
            n.dll = req.wdata;
          end else begin
            tx_push = 1'b1;
          end
        end
        ADDR_IER: begin
          if (s.line_control[LCR_DIVISOR_LATCH_ACCESS]) begin
            n.divisor_high_byte = req.wdata;
          end else begin
            n.interrupt_enable[3:0] = req.wdata[3:0];
            if (enh) begin
              n.interrupt_enable[7:4] = req.wdata[7:4];
            end
          end
        end
        ADDR_IIR_FCR: begin
          if (bf) begin
            n.enhanced_features = req.wdata;
          end else begin
            n.fifo_en = req.wdata[FCR_EN];
            n.dma_mode = req.wdata[FCR_DMA];
            n.rx_trig = req.wdata[7:6];
            if (enh) begin
              n.tx_trig = req.wdata[5:4];
            end
            // Switching FIFO mode discards both queues
            rx_clr = req.wdata[FCR_RX_CLR] | (req.wdata[FCR_EN] != s.fifo_en);
            tx_clr = req.wdata[FCR_TX_CLR] | (req.wdata[FCR_EN] != s.fifo_en);
          end
        end
        ADDR_LCR: n.line_control = req.wdata;
        ADDR_MCR: begin
          if (bf) begin
            n.resume_char_one = req.wdata;
          end else begin
            n.modem_control[4:0] = req.wdata[4:0];
            if (enh) begin
              n.modem_control[7:5] = req.wdata[7:5];
            end
          end
        end
        ADDR_LSR: begin
          if (bf) begin
            n.resume_char_two = req.wdata;
          end
        end
        ADDR_MSR: begin
          if (bf) begin
            n.halt_char_one = req.wdata;
          end else if (tcr_ok) begin
            n.flow_thresholds = req.wdata;
          end
        end
        ADDR_SCRATCH: begin
          if (bf) begin
            n.halt_char_two = req.wdata;
          end else if (tcr_ok) begin
            n.fifo_trigger_levels = req.wdata;
          end else begin
            n.scratch_byte = req.wdata;
          end
        end
        default: ;
      endcase
    end

    // Transmitter; ticks stop while asleep
    case (s.tx_st)
      LS_IDLE: begin
        n.tx_line = 1'b1;
        if (tick && tx_valid) begin
          tx_pop = 1'b1;
          n.tx_sh = tx_top & data_mask(s.line_control);
          n.tx_par = par_bit(s.line_control, tx_top);
          n.tx_cnt = '0;
          n.tx_st = LS_START;
        end
      end
      LS_START, LS_DATA, LS_PAR, LS_STOP: begin
        n.tx_line = (s.tx_st == LS_START) ? 1'b0 : (s.tx_st == LS_DATA) ? s.tx_sh[0]
          : (s.tx_st == LS_PAR) ? s.tx_par : 1'b1;
        if (tick) begin
          n.tx_cnt = s.tx_cnt + 6'd1;
          if (s.tx_st == LS_STOP && s.tx_cnt == stop_ticks(s.line_control) - 6'd1) begin
            n.tx_st = LS_IDLE;
          end else if (s.tx_st != LS_STOP && s.tx_cnt == 6'(OVERSAMPLE - 1)) begin
            n.tx_cnt = '0;
            if (s.tx_st == LS_START) begin
              n.tx_bit = '0;
              n.tx_st = LS_DATA;
            end else if (s.tx_st == LS_DATA) begin
              n.tx_sh = s.tx_sh >> 1;
              n.tx_bit = s.tx_bit + 3'd1;
              if (4'(s.tx_bit) == wl - 4'd1) begin
                n.tx_st = s.line_control[LCR_PAR_EN] ? LS_PAR : LS_STOP;
              end
            end else begin
              n.tx_st = LS_STOP;
            end
          end
        end
      end
      default: n.tx_st = LS_IDLE;
    endcase
    // Loopback keeps the pin at mark; otherwise break forces it low
    n.tx_out = s.modem_control[MCR_LOOP] ? 1'b1 : (n.tx_line & ~s.line_control[LCR_BREAK]);

    // Receiver; first check at half a bit, then every full bit
    case (s.rx_st)
      LS_IDLE: begin
        if (tick && !rx_in) begin
          n.rx_cnt = '0;
          n.rx_st = LS_START;
        end
      end
      LS_START: begin
        if (tick) begin
          n.rx_cnt = s.rx_cnt + 6'd1;
          if (s.rx_cnt == 6'(HALF_BIT - 1)) begin
            n.rx_cnt = '0;
            n.rx_bit = '0;
            n.rx_st = rx_in ? LS_IDLE : LS_DATA;
          end
        end
      end
      LS_DATA, LS_PAR, LS_STOP: begin
        if (tick) begin
          n.rx_cnt = s.rx_cnt + 6'd1;
          if (s.rx_cnt == 6'(OVERSAMPLE - 1)) begin
            n.rx_cnt = '0;
            if (s.rx_st == LS_DATA) begin
              n.rx_sh = {rx_in, s.rx_sh[7:1]};
              n.rx_bit = s.rx_bit + 3'd1;
              if (4'(s.rx_bit) == wl - 4'd1) begin
                n.rx_st = s.line_control[LCR_PAR_EN] ? LS_PAR : LS_STOP;
              end
            end else if (s.rx_st == LS_PAR) begin
              n.rx_par = rx_in;
              n.rx_st = LS_STOP;
            end else begin
              d = s.rx_sh >> (4'd8 - wl);
              rx_ent.data = d;
              rx_ent.frame_err = ~rx_in;
              rx_ent.par_err = s.line_control[LCR_PAR_EN] & (s.rx_par != par_bit(s.line_control, d));
              rx_ent.brk = (d == 8'h00) & ~rx_in & ~(s.line_control[LCR_PAR_EN] & s.rx_par);
              rx_push = 1'b1;
              if (!rx_ready || (!s.fifo_en && rx_valid && !rx_pop)) begin
                n.overrun = 1'b1;
              end
              n.rx_st = LS_IDLE;
            end
          end
        end
      end
      default: n.rx_st = LS_IDLE;
    endcase

    // Idle detector runs on 16x ticks; a low line clears it at once
    if (!rx_in) begin
      n.idle_cnt = '0;
      n.rx_idle = 1'b0;
    end else if (tick && !s.rx_idle) begin
      if (s.idle_cnt == 10'(IDLE_CHARS) * char_ticks(s.line_control) - 10'd1) begin
        n.rx_idle = 1'b1;
      end else begin
        n.idle_cnt = s.idle_cnt + 10'd1;
      end
    end

    // Sleep control
    allowed = s.enhanced_features[EFR_ENH] & s.interrupt_enable[IER_SLEEP];
    wake = (rx_in != s.rx_last) | (msr_now != s.msr_lvl) | tx_push;
    if (s.asleep) begin
      if (wake || !allowed) begin
        n.asleep = 1'b0;
      end
    end else if (allowed && s.rx_idle && !tx_valid && s.tx_st == LS_IDLE && !wake
        && !rx_valid && !(pend && !(prio == PRIO_THR)) && !tx_push) begin
      n.asleep = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      s <= reset_state();
    end else begin
      s <= n;
    end
  end

  assign o_rdata = s.rdata;
  assign o_tx = s.tx_out;
  assign o_asleep = s.asleep;
  assign o_rx_idle = s.rx_idle;
endmodule : uart_channel

// ===== tb/uart_channel_props.sv
// Concurrent checks on the UART channel ports
`timescale 1ns/1ps
module uart_channel_props import uart_chan_pkg::*; (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_cs_n,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_rx,
  input wire logic [7:0] o_rdata,
  input wire logic o_tx,
  input wire logic o_asleep,
  input wire logic o_rx_idle
);
  // Shortest frame is 7 bits, 16 clocks each at the fastest divisor
  localparam int MIN_IDLE = 448;
  logic [11:0] hi_cnt;
  logic take;
  assign take = !i_cs_n && !i_rd_n;
  always_ff @(posedge i_clk) begin
    if (!i_resetn || !i_rx) begin
      hi_cnt <= 12'h000;
    end else if (hi_cnt != 12'hFFF) begin
      hi_cnt <= hi_cnt + 12'h001;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  reset_outputs_a: assert property ($rose(i_resetn) |-> o_tx && !o_asleep && !o_rx_idle)
    else $error("outputs not at reset level");
  break_forces_low_a: assert property (
    !i_cs_n && !i_wr_n && i_addr == ADDR_LCR && i_wdata[LCR_BREAK] |-> ##2 !o_tx)
    else $error("tx not low under break");
  rdata_stands_a: assert property (
    !$past(take) && !$past(take, 2) |-> $stable(o_rdata))
    else $error("read data changed without a read");
  sleep_needs_idle_a: assert property ($rose(o_asleep) |-> o_rx_idle)
    else $error("sleep entered with rx not idle");
  asleep_tx_high_a: assert property (o_asleep |-> o_tx)
    else $error("tx active while asleep");
  wake_on_rx_a: assert property (o_asleep && $changed(i_rx) |-> ##[1:5] !o_asleep)
    else $error("no wake after rx change");
  wake_on_write_a: assert property (
    o_asleep && !i_cs_n && !i_wr_n && i_addr == ADDR_HOLD |-> ##[1:3] !o_asleep)
    else $error("no wake after transmit write");
  idle_time_a: assert property ($rose(o_rx_idle) |-> hi_cnt >= MIN_IDLE)
    else $error("rx idle flagged too early");
endmodule : uart_channel_props

// ===== tb/serial_peer.sv
// Serial peer: sends 8N1 frames on rx and decodes frames seen on tx
`timescale 1ns/1ps
module serial_peer #(
  parameter int BIT = 16
) (
  input wire logic i_clk,
  input wire logic i_tx,
  output logic o_rx,
  output logic [7:0] o_got
);
  initial begin
    o_rx = 1'b1;
    o_got = 8'h00;
    forever begin
      @(negedge i_tx);
      repeat (BIT / 2) @(posedge i_clk);
      for (int n = 0; n < 8; n++) begin
        repeat (BIT) @(posedge i_clk);
        o_got[n] = i_tx;
      end
      repeat (BIT) @(posedge i_clk);
    end
  end
  // Divisor 1 assumed: one bit lasts sixteen clocks
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int k = 0; k < 10; k++) begin
      o_rx <= f[k];
      repeat (BIT) @(posedge i_clk);
    end
  endtask : send
endmodule : serial_peer

// ===== tb/uart_channel_test.sv
// Self-checking bench for one UART channel
`timescale 1ns/1ps
module uart_channel_test;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_cs_n = 1'b1;
  logic i_all_cs_n = 1'b0;
  logic i_rd_n = 1'b1;
  logic i_wr_n = 1'b1;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic [2:0] i_peer_rx_rdy = 3'h5;
  logic [2:0] i_peer_tx_rdy = 3'h2;
  logic [3:0] i_modem_n = 4'hF;
  logic i_rx;
  logic [7:0] o_rdata;
  logic o_tx;
  logic o_asleep;
  logic o_rx_idle;
  logic [7:0] got;
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;
  always #2.5 i_clk = ~i_clk;
  uart_channel uart_channel_i (.i_clk, .i_resetn, .i_cs_n, .i_all_cs_n, .i_rd_n, .i_wr_n,
    .i_addr, .i_wdata, .o_rdata, .i_peer_rx_rdy, .i_peer_tx_rdy, .i_rx, .i_modem_n,
    .o_tx, .o_asleep, .o_rx_idle);
  serial_peer serial_peer_i (.i_clk(i_clk), .i_tx(o_tx), .o_rx(i_rx), .o_got(got));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #1;
    {i_cs_n, i_wr_n, i_addr, i_wdata} = {2'b00, a, d};
    @(posedge i_clk);
    #1;
    {i_cs_n, i_wr_n} = 2'b11;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge i_clk);
    #1;
    {i_cs_n, i_rd_n, i_addr} = {2'b00, a};
    @(posedge i_clk);
    #1;
    {i_cs_n, i_rd_n} = 2'b11;
    @(posedge i_clk);
    #1;
    chk(o_rdata, e);
  endtask : rd
  // Bounded wait on the idle or sleep flag, sampled clear of the edge
  // Wake may last one cycle only, so the value seen is the one checked
  task automatic await(input logic idle, input logic want);
    logic v;
    v = ~want;
    for (int k = 0; k < 3000 && v !== want; k++) begin
      @(posedge i_clk);
      #1;
      v = idle ? o_rx_idle : o_asleep;
    end
    chk({7'h00, v}, {7'h00, want});
  endtask : await
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    repeat (3) @(posedge i_clk);
    #1;
    i_resetn = 1'b1;
    rd(3'h3, 8'h1D);
    rd(3'h5, 8'h60);
    wr(3'h7, 8'h5A);
    rd(3'h7, 8'h5A);
    wr(3'h5, 8'h00);
    rd(3'h5, 8'h60);
    wr(3'h1, 8'hFF);
    rd(3'h1, 8'h0F);
    wr(3'h1, 8'h00);
    wr(3'h4, 8'h04);
    rd(3'h7, 8'hA5);
    i_all_cs_n = 1'b1;
    rd(3'h7, 8'h5A);
    wr(3'h4, 8'h00);
    $display("test registers done");
    wr(3'h0, 8'hA5);
    repeat (100) @(posedge i_clk);
    #1;
    chk({7'h00, o_tx}, 8'h01);
    rd(3'h5, 8'h00);
    wr(3'h3, 8'h83);
    wr(3'h0, 8'h01);
    wr(3'h1, 8'h00);
    rd(3'h0, 8'h01);
    wr(3'h3, 8'h03);
    repeat (250) @(posedge i_clk);
    chk(got, 8'hA5);
    serial_peer_i.send(8'h3C);
    repeat (20) @(posedge i_clk);
    rd(3'h5, 8'h61);
    rd(3'h0, 8'h3C);
    wr(3'h3, 8'h43);
    @(posedge i_clk);
    #1;
    chk({7'h00, o_tx}, 8'h00);
    wr(3'h3, 8'h03);
    wr(3'h3, 8'hBF);
    wr(3'h2, 8'h10);
    wr(3'h3, 8'h03);
    wr(3'h4, 8'h80);
    rd(3'h4, 8'h80);
    // Divide-by-4: frame still shifting well past 160 clocks
    wr(3'h0, 8'h5C);
    repeat (200) @(posedge i_clk);
    #1;
    rd(3'h5, 8'h20);
    repeat (500) @(posedge i_clk);
    wr(3'h4, 8'h00);
    $display("test serial done");
    await(1'b1, 1'b1);
    wr(3'h1, 8'h10);
    await(1'b0, 1'b1);
    i_modem_n = 4'hE;
    await(1'b0, 1'b0);
    await(1'b0, 1'b1);
    wr(3'h0, 8'h77);
    await(1'b0, 1'b0);
    repeat (250) @(posedge i_clk);
    chk(got, 8'h77);
    await(1'b0, 1'b1);
    serial_peer_i.send(8'h11);
    // Four character times plus margin with a byte still held
    repeat (1000) @(posedge i_clk);
    #1;
    chk({7'h00, o_asleep}, 8'h00);
    rd(3'h0, 8'h11);
    await(1'b0, 1'b1);
    $display("test sleep done");
    print_verdict();
  end
endmodule : uart_channel_test
bind uart_channel uart_channel_props uart_channel_props_i (.i_clk, .i_resetn, .i_cs_n,
  .i_rd_n, .i_wr_n, .i_addr, .i_wdata, .i_rx, .o_rdata, .o_tx, .o_asleep, .o_rx_idle);
